// *** hhi_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module hhi_asserts (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire hhi_pkg::hhi_axi_req_t axi_req,
    input wire hhi_pkg::hhi_axi_rsp_t axi_rsp,
    input wire hhi_pkg::hhi_stat_t    stat,
    input wire logic [31:0]           lf_word,
    input wire logic                  dpll_locked,
    input wire logic                  ref_valid,
    input wire logic                  holdover_mode,
    input wire logic [15:0]           freq_err,
    input wire logic [31:0]           tuning_word_r,
    input wire logic [1:0]            gpio_out_r,
    input wire logic [1:0]            gpio_oe_r
);
    import hhi_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_tune_lock:
    assert property (ce && !rst && dpll_locked |=> tuning_word_r == $past(lf_word))
        else $error("tuning word not from loop filter");
    chk_rst_idle:
    assert property ($fell(rst) |-> !axi_rsp.bvalid && !axi_rsp.rvalid && tuning_word_r == 32'h0
        && gpio_oe_r == 2'h0)
        else $error("outputs not idle after reset");
    chk_rd_lat:
    assert property (ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    chk_wr_lat:
    assert property (ce && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write answer off time");
    chk_b_hold:
    assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped");
    chk_r_hold:
    assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
    chk_ar_refuse:
    assert property (axi_req.arvalid && axi_rsp.arready |=> !axi_rsp.arready)
        else $error("read address taken twice");
    chk_aw_refuse:
    assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
        else $error("write address taken twice");
endmodule : hhi_asserts

bind hhi_top hhi_asserts u_chk (.clk(clk), .rst(rst), .ce(ce), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .stat(stat), .lf_word(lf_word), .dpll_locked(dpll_locked),
    .ref_valid(ref_valid), .holdover_mode(holdover_mode), .freq_err(freq_err),
    .tuning_word_r(tuning_word_r), .gpio_out_r(gpio_out_r), .gpio_oe_r(gpio_oe_r));
`default_nettype wire

// *** hhi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Host side of the status pins
// ****
module hhi_host (
    input  wire logic [1:0] gpio_out_r,
    input  wire logic [1:0] gpio_oe_r,
    output logic [1:0]      pin
);
    // Pull-up on each pin
    // Released pin reads high, so open drain is seen as on a board
    assign pin = (gpio_out_r & gpio_oe_r) | ~gpio_oe_r;
endmodule : hhi_host
`default_nettype wire

// *** hhi_pkg.sv ***
package hhi_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] HHI_HIST_CTRL = 8'h00;
    localparam logic [7:0] HHI_FREERUN   = 8'h04;
    localparam logic [7:0] HHI_HOLD_WORD = 8'h08;
    localparam logic [7:0] HHI_TUNING    = 8'h0C;
    localparam logic [7:0] HHI_INT_CTRL  = 8'h10;
    localparam logic [7:0] HHI_INT_POL   = 8'h14;
    localparam logic [7:0] HHI_INT_MASK  = 8'h18;
    localparam logic [7:0] HHI_INT_FLAG  = 8'h1C;
    localparam logic [7:0] HHI_LIVE      = 8'h20;
    localparam logic [7:0] HHI_LOCK_THR  = 8'h24;
    localparam logic [7:0] HHI_GPIO_CFG  = 8'h28;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          HHI_HIST_EN_BIT  = 0;
    localparam int          HHI_WIN_LSB      = 8;
    localparam int          HHI_INT_EN_BIT   = 0;
    localparam int          HHI_INT_AND_BIT  = 1;
    localparam int          HHI_INTERRUPT_CLEAR_FIELD_BIT  = 2;
    localparam int          HHI_GPIO_INV_BIT = 4;
    localparam int          HHI_GPIO_OD_BIT  = 5;
    localparam int          HHI_NSRC         = 7;
    localparam int          HHI_NGPIO        = 2;
    localparam logic [31:0] HHI_FREERUN_RST  = 32'h0000_0000;
    localparam logic [3:0]  HHI_WIN_RST      = 4'h4;
    localparam logic [6:0]  HHI_POL_RST      = 7'h7F;
    localparam logic [6:0]  HHI_MASK_RST     = 7'h7F;
    localparam logic [31:0] HHI_THR_RST      = 32'h0020_0010;
    localparam logic [15:0] HHI_GPIO_RST     = 16'h0707;
    localparam logic [1:0]  HHI_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  HHI_RESP_SLVERR  = 2'h2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } hhi_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } hhi_axi_rsp_t;

    typedef struct packed {
        logic xo_signal_loss;
        logic reference_loss;
        logic apll1_lock_loss;
        logic apll2_lock_loss;
        logic holdover_event;
        logic switchover_event;
    } hhi_stat_t;

endpackage : hhi_pkg

// *** hhi_top.sv ***
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module hhi_top (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire hhi_pkg::hhi_axi_req_t  axi_req,
    output var  hhi_pkg::hhi_axi_rsp_t  axi_rsp,
    input  wire hhi_pkg::hhi_stat_t     stat,
    input  wire logic [31:0]            lf_word,
    input  wire logic                   dpll_locked,
    input  wire logic                   ref_valid,
    input  wire logic                   holdover_mode,
    input  wire logic [15:0]            freq_err,
    output logic [31:0]                 tuning_word_r,
    output logic [1:0]                  gpio_out_r,
    output logic [1:0]                  gpio_oe_r
);
    import hhi_pkg::*;

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic        awready_r;
    logic        wready_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        wr_fire;
    logic        rd_hit;
    logic [31:0] rd_mux;
    logic        wr_hit;

    assign axi_rsp.awready = awready_r;
    assign axi_rsp.wready  = wready_r;
    assign axi_rsp.bresp   = bresp_r;
    assign axi_rsp.bvalid  = bvalid_r;
    assign axi_rsp.arready = arready_r;
    assign axi_rsp.rdata   = rdata_r;
    assign axi_rsp.rresp   = rresp_r;
    assign axi_rsp.rvalid  = rvalid_r;

    assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            awready_r <= 1'b0;
            aw_got_r  <= 1'b0;
            aw_addr_r <= 8'h00;
        end
        else if (ce)
        begin
            if (axi_req.awvalid && awready_r)
            begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= axi_req.awaddr;
                awready_r <= 1'b0;
            end
            else
            begin
                if (wr_fire)
                begin
                    aw_got_r <= 1'b0;
                end
                if (!aw_got_r && !bvalid_r)
                begin
                    awready_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wready_r <= 1'b0;
            w_got_r  <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else if (ce)
        begin
            if (axi_req.wvalid && wready_r)
            begin
                w_got_r  <= 1'b1;
                w_data_r <= axi_req.wdata;
                w_strb_r <= axi_req.wstrb;
                wready_r <= 1'b0;
            end
            else
            begin
                if (wr_fire)
                begin
                    w_got_r <= 1'b0;
                end
                if (!w_got_r && !bvalid_r)
                begin
                    wready_r <= 1'b1;
                end
            end
        end
    end

    // Writes to read-only or unmapped words answer SLVERR
    always_comb
    begin
        case (aw_addr_r)
            HHI_HIST_CTRL, HHI_FREERUN, HHI_INT_CTRL, HHI_INT_POL,
            HHI_INT_MASK, HHI_LOCK_THR, HHI_GPIO_CFG: wr_hit = 1'b1;
            default:                                  wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= HHI_RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? HHI_RESP_OKAY : HHI_RESP_SLVERR;
            end
            else if (axi_req.bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= HHI_RESP_OKAY;
        end
        else if (ce)
        begin
            if (axi_req.arvalid && arready_r)
            begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_mux;
                rresp_r   <= rd_hit ? HHI_RESP_OKAY : HHI_RESP_SLVERR;
            end
            else if (rvalid_r && axi_req.rready)
            begin
                rvalid_r <= 1'b0;
            end
            else if (!rvalid_r)
            begin
                arready_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    logic        hist_en_r;
    logic [3:0]  win_r;
    logic [31:0] freerun_r;
    logic [1:0]  int_ctrl_r;
    logic        interrupt_clear_field;
    logic [6:0]  pol_r;
    logic [6:0]  mask_r;
    logic [31:0] thr_r;
    logic [15:0] gpio_cfg_r;
    logic [31:0] wv;

    assign wv = w_data_r;
    assign interrupt_clear_field = wr_fire && aw_addr_r == HHI_INT_CTRL
                     && w_strb_r[0] && wv[HHI_INTERRUPT_CLEAR_FIELD_BIT];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hist_en_r  <= 1'b0;
            win_r      <= HHI_WIN_RST;
            freerun_r  <= HHI_FREERUN_RST;
            int_ctrl_r <= 2'h0;
            pol_r      <= HHI_POL_RST;
            mask_r     <= HHI_MASK_RST;
            thr_r      <= HHI_THR_RST;
            gpio_cfg_r <= HHI_GPIO_RST;
        end
        else if (ce && wr_fire)
        begin
            case (aw_addr_r)
                HHI_HIST_CTRL:
                begin
                    if (w_strb_r[0])
                    begin
                        hist_en_r <= wv[HHI_HIST_EN_BIT];
                    end
                    if (w_strb_r[1])
                    begin
                        win_r <= wv[HHI_WIN_LSB +: 4];
                    end
                end
                HHI_FREERUN:  freerun_r <= wmerge(freerun_r, wv, w_strb_r);
                HHI_INT_CTRL:
                begin
                    if (w_strb_r[0])
                    begin
                        int_ctrl_r <= wv[1:0];
                    end
                end
                HHI_INT_POL:  pol_r <= w_strb_r[0] ? wv[6:0] : pol_r;
                HHI_INT_MASK: mask_r <= w_strb_r[0] ? wv[6:0] : mask_r;
                HHI_LOCK_THR: thr_r <= wmerge(thr_r, wv, w_strb_r);
                HHI_GPIO_CFG:
                    gpio_cfg_r <= 16'(wmerge({16'h0000, gpio_cfg_r}, wv, w_strb_r));
                default: ;
            endcase
        end
    end

    // ************************************************************
    // History monitor
    // ************************************************************
    logic               hist_en_d_r;
    logic               ref_valid_d_r;
    logic signed [47:0] acc_r;
    logic signed [47:0] acc_sum;
    logic [15:0]        cnt_r;
    logic [31:0]        avg_cur_r;
    logic [31:0]        avg_prev_r;
    logic               cur_v_r;
    logic               prev_v_r;
    logic [31:0]        hold_word_r;
    logic               accum;
    logic               win_done;
    logic               ref_fail;
    logic               hist_clr;

    // Accumulate only while enabled, locked and reference valid
    assign accum    = hist_en_r & dpll_locked & ref_valid;
    assign acc_sum  = acc_r + 48'(signed'(lf_word));
    assign win_done = accum && cnt_r == 16'((17'h1 << win_r) - 17'h1);
    assign ref_fail = ref_valid_d_r & ~ref_valid;
    assign hist_clr = hist_en_r & ~hist_en_d_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hist_en_d_r   <= 1'b0;
            ref_valid_d_r <= 1'b0;
        end
        else if (ce)
        begin
            hist_en_d_r   <= hist_en_r;
            ref_valid_d_r <= ref_valid;
        end
    end

    // Partial window dropped when reference fails
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_r <= 48'h0000_0000_0000;
            cnt_r <= 16'h0000;
        end
        else if (ce)
        begin
            if (!accum || win_done || ref_fail || hist_clr)
            begin
                acc_r <= 48'h0000_0000_0000;
                cnt_r <= 16'h0000;
            end
            else
            begin
                acc_r <= acc_sum;
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Reset wipes history; nothing else but a toggle does
    always_ff @(posedge clk)
    begin
        if (rst || (ce && hist_clr))
        begin
            avg_cur_r  <= 32'h0000_0000;
            avg_prev_r <= 32'h0000_0000;
            cur_v_r    <= 1'b0;
            prev_v_r   <= 1'b0;
        end
        else if (ce)
        begin
            if (ref_fail)
            begin
                avg_cur_r <= avg_prev_r;
                cur_v_r   <= prev_v_r;
                prev_v_r  <= 1'b0;
            end
            else if (win_done)
            begin
                avg_cur_r  <= 32'(acc_sum >>> win_r);
                cur_v_r    <= 1'b1;
                avg_prev_r <= avg_cur_r;
                prev_v_r   <= cur_v_r;
            end
        end
    end

    // Frozen while reference is gone and a current average is valid, so late updates cannot leak in
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hold_word_r <= HHI_FREERUN_RST;
        end
        else if (ce && (ref_valid || !cur_v_r))
        begin
            // Last good average; else freerun word
            hold_word_r <= prev_v_r ? avg_prev_r : freerun_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tuning_word_r <= HHI_FREERUN_RST;
        end
        else if (ce)
        begin
            if (dpll_locked)
            begin
                tuning_word_r <= lf_word;
            end
            else if (holdover_mode)
            begin
                tuning_word_r <= hold_word_r;
            end
            else
            begin
                tuning_word_r <= freerun_r;
            end
        end
    end

    // ************************************************************
    // Status and interrupt
    // ************************************************************
    logic       frequency_lock_loss_r;
    logic [6:0] live;
    logic [6:0] live_d_r;
    logic [6:0] edge_ev;
    logic [6:0] flag_r;
    logic       int_r;

    // Hysteresis between lock and unlock thresholds
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            frequency_lock_loss_r <= 1'b1;
        end
        else if (ce)
        begin
            if (freq_err < thr_r[15:0])
            begin
                frequency_lock_loss_r <= 1'b0;
            end
            else if (freq_err > thr_r[31:16])
            begin
                frequency_lock_loss_r <= 1'b1;
            end
        end
    end

    assign live = {stat.switchover_event, stat.holdover_event, frequency_lock_loss_r,
                   stat.apll2_lock_loss, stat.apll1_lock_loss,
                   stat.reference_loss, stat.xo_signal_loss};
    assign edge_ev = (pol_r & live & ~live_d_r) | (~pol_r & ~live & live_d_r);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            live_d_r <= 7'h00;
            flag_r   <= 7'h00;
        end
        else if (ce)
        begin
            live_d_r <= live;
            // Sticky; a new edge beats a same-cycle clear
            flag_r <= (flag_r & ~{HHI_NSRC{interrupt_clear_field}})
                      | (edge_ev & {HHI_NSRC{int_ctrl_r[HHI_INT_EN_BIT]}});
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            int_r <= 1'b0;
        end
        else if (ce)
        begin
            // Masked flags ignored; AND or OR merge
            if (int_ctrl_r[HHI_INT_AND_BIT])
            begin
                int_r <= int_ctrl_r[HHI_INT_EN_BIT] & ~&mask_r
                         & &(flag_r | mask_r);
            end
            else
            begin
                int_r <= int_ctrl_r[HHI_INT_EN_BIT] & |(flag_r & ~mask_r);
            end
        end
    end

    // ************************************************************
    // GPIO status pins
    // ************************************************************
    logic [15:0] gsrc;

    assign gsrc = {1'b0, flag_r, int_r, live};

    genvar g;
    generate
        for (g = 0; g < HHI_NGPIO; g++)
        begin : gp
            logic [7:0] cfg;
            logic       lvl;
            assign cfg = gpio_cfg_r[g*8 +: 8];
            assign lvl = gsrc[cfg[3:0]] ^ cfg[HHI_GPIO_INV_BIT];
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    gpio_out_r[g] <= 1'b0;
                    gpio_oe_r[g]  <= 1'b0;
                end
                else if (ce)
                begin
                    gpio_out_r[g] <= cfg[HHI_GPIO_OD_BIT] ? 1'b0 : lvl;
                    gpio_oe_r[g]  <= cfg[HHI_GPIO_OD_BIT] ? ~lvl : 1'b1;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb
    begin
        rd_hit = 1'b1;
        case (axi_req.araddr)
            HHI_HIST_CTRL: rd_mux = {20'h00000, win_r, 7'h00, hist_en_r};
            HHI_FREERUN:   rd_mux = freerun_r;
            HHI_HOLD_WORD: rd_mux = hold_word_r;
            HHI_TUNING:    rd_mux = tuning_word_r;
            HHI_INT_CTRL:  rd_mux = {30'h0000_0000, int_ctrl_r};
            HHI_INT_POL:   rd_mux = {25'h000_0000, pol_r};
            HHI_INT_MASK:  rd_mux = {25'h000_0000, mask_r};
            HHI_INT_FLAG:  rd_mux = {25'h000_0000, flag_r};
            HHI_LIVE:      rd_mux = {23'h00_0000, int_r, prev_v_r, live};
            HHI_LOCK_THR:  rd_mux = thr_r;
            HHI_GPIO_CFG:  rd_mux = {16'h0000, gpio_cfg_r};
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

endmodule : hhi_top

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_top;
    import hhi_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         ce = 1'b1;
    hhi_axi_req_t rq;
    hhi_axi_rsp_t rs;
    hhi_stat_t    stat;
    logic [31:0]  lf, fr, av;
    logic         lock, rv, hm, rnd;
    logic [15:0]  fe;
    logic [1:0]   go, goe, pin;
    logic [65:0]  e;
    logic [65:0]  q[$];
    logic [1:0]   bq[$];
    int           fail_count = 0;
    int           tests_run = 0;
    int           seed = 29;

    task automatic chk(input logic [33:0] a, input logic [33:0] b);
        tests_run++;
        if (a !== b)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = HHI_RESP_OKAY);
        int n = 0;
        @(posedge clk);
        bq.push_back(r);
        rq.awaddr <= a;
        rq.wdata <= d;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rs.awready)
                rq.awvalid <= 1'b0;
            if (rs.wready)
                rq.wvalid <= 1'b0;
            n++;
        end
        while (!rs.bvalid && n < 99);
        rq.bready <= 1'b0;
        if (!rs.bvalid)
            fail_count++;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] r = HHI_RESP_OKAY);
        int n = 0;
        @(posedge clk);
        q.push_back({r, m, d & m});
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rs.arready)
                rq.arvalid <= 1'b0;
            n++;
        end
        while (!rs.rvalid && n < 99);
        rq.rready <= 1'b0;
        if (!rs.rvalid)
            fail_count++;
    endtask : rd

    task automatic summarize;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    hhi_top dut (.clk(clk), .rst(rst), .ce(ce), .axi_req(rq), .axi_rsp(rs), .stat(stat),
        .lf_word(lf), .dpll_locked(lock), .ref_valid(rv), .holdover_mode(hm), .freq_err(fe),
        .tuning_word_r(), .gpio_out_r(go), .gpio_oe_r(goe));
    hhi_host host (.gpio_out_r(go), .gpio_oe_r(goe), .pin(pin));

    always #12.5 clk = ~clk;

    always @(posedge clk)
        if (rnd)
            lf <= $random(seed);

    // Oldest note is matched to each answer
    always @(posedge clk)
    begin
        if (rs.rvalid && rq.rready)
        begin
            e = q.pop_front();
            chk({rs.rresp, rs.rdata & e[63:32]}, {e[65:64], e[31:0]});
        end
        if (rs.bvalid && rq.bready)
            chk({32'h0, rs.bresp}, {32'h0, bq.pop_front()});
    end

    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end

    initial
    begin
        rq = '0;
        rq.wstrb = 4'hF;
        stat = '0;
        {lf, lock, hm, rnd, fe} = '0;
        rv = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(HHI_HIST_CTRL, 32'h400);
        rd(HHI_INT_CTRL, 32'h0);
        rd(HHI_INT_POL, 32'h7F);
        rd(HHI_INT_MASK, 32'h7F);
        rd(HHI_LOCK_THR, 32'h0020_0010);
        rd(HHI_GPIO_CFG, 32'h0707);
        rd(8'h3C, 32'h0, 32'hFFFF_FFFF, HHI_RESP_SLVERR);
        wr(HHI_INT_FLAG, 32'h1, HHI_RESP_SLVERR);
        $display("test registers done");
        fr = $random(seed);
        wr(HHI_FREERUN, fr);
        rd(HHI_TUNING, fr);
        hm <= 1'b1;
        rd(HHI_HOLD_WORD, fr);
        rd(HHI_TUNING, fr);
        rnd <= 1'b1;
        lock <= 1'b1;
        hm <= 1'b0;
        repeat (20) @(posedge clk);
        rnd <= 1'b0;
        @(posedge clk);
        av = $random(seed);
        lf <= av;
        wr(HHI_HIST_CTRL, 32'h401);
        rd(HHI_HOLD_WORD, fr);
        repeat (40) @(posedge clk);
        rd(HHI_HOLD_WORD, av);
        // Short second run: at most one mixed window can finish
        lf <= ~av;
        repeat (10) @(posedge clk);
        rv <= 1'b0;
        lock <= 1'b0;
        hm <= 1'b1;
        rd(HHI_HOLD_WORD, av);
        rd(HHI_TUNING, av);
        rv <= 1'b1;
        lock <= 1'b1;
        hm <= 1'b0;
        repeat (20) @(posedge clk);
        rd(HHI_HOLD_WORD, av);
        wr(HHI_HIST_CTRL, 32'h400);
        wr(HHI_HIST_CTRL, 32'h401);
        rd(HHI_HOLD_WORD, fr);
        repeat (40) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(HHI_HOLD_WORD, 32'h0);
        $display("test history done");
        wr(HHI_INT_CTRL, 32'h1);
        wr(HHI_INT_MASK, 32'h0);
        for (int j = 5; j >= 0; j--)
        begin
            stat <= hhi_stat_t'(6'h1 << j);
            repeat (4) @(posedge clk);
            chk({32'h0, pin}, 34'h3);
            stat <= '0;
            rd(HHI_INT_FLAG, 32'h1 << (j > 1 ? 5 - j : 6 - j), 32'h7F);
            wr(HHI_INT_CTRL, 32'h5);
            rd(HHI_INT_FLAG, 32'h0, 32'h7F);
        end
        rd(HHI_INT_CTRL, 32'h1);
        fe <= 16'h18;
        rd(HHI_LIVE, 32'h0, 32'h10);
        fe <= 16'h30;
        repeat (4) @(posedge clk);
        fe <= 16'h18;
        rd(HHI_INT_FLAG, 32'h10, 32'h7F);
        rd(HHI_LIVE, 32'h10, 32'h10);
        wr(HHI_INT_CTRL, 32'h5);
        wr(HHI_INT_MASK, 32'h7C);
        wr(HHI_GPIO_CFG, 32'h3707);
        wr(HHI_INT_CTRL, 32'h3);
        stat <= hhi_stat_t'(6'h20);
        repeat (4) @(posedge clk);
        chk({32'h0, pin}, 34'h2);
        stat <= hhi_stat_t'(6'h30);
        repeat (4) @(posedge clk);
        chk({32'h0, pin}, 34'h1);
        wr(HHI_INT_CTRL, 32'h7);
        wr(HHI_INT_POL, 32'h0);
        stat <= '0;
        repeat (4) @(posedge clk);
        chk({32'h0, pin}, 34'h1);
        wr(HHI_INT_MASK, 32'h7F);
        repeat (4) @(posedge clk);
        chk({32'h0, pin}, 34'h2);
        rd(HHI_INT_FLAG, 32'h3, 32'h7F);
        $display("test interrupts done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
